// *** logic/pci_pkg.sv ***
// Shared constants, types and helpers for both ends of the PCI port
//
// Behaviour
// [R1] Driver pulls shared line high before releasing it
// [R2] New owner waits one clock after release
// [R3] One address phase, then data phases, shared lines
// [R4] Address phase is the first frame clock
// [R5] I/O addresses bytes; memory addresses words; the target picks a word for both and ignores the low address bits
// [R6] Most significant byte on top lanes
// [R7] Command during address, byte enables during data
// [R8] Enables valid whole phase; only enabled lanes count
// [R9] Enable bit three qualifies top lane
// [R10] Parity makes all bits even
// [R11] Address parity valid the clock after address
// [R12] Data parity one clock after ready
// [R13] Parity holds until one clock after completion
// [R14] Initiator parity address/write; target parity read
// [R15] Phase completes when both readies asserted
// [R16] Frame released during final data phase
// [R17] Data parity error reported two clocks later; only the initiator checks, on read data, the target checks no write parity
// [R18] Parity registered from previous clock values
package pci_pkg;

	// ----------------------------------------
	// Widths and sizes
	// ----------------------------------------
	localparam int AD_W = 32;
	localparam int BE_W = 4;
	localparam int BYTE_W = 8;
	localparam int CNT_W = 8;
	localparam int FIFO_DEPTH = 8;
	localparam int DEVSEL_WAIT = 5;
	localparam int IDX_LSB = 2;

	// ----------------------------------------
	// Levels and codes
	// ----------------------------------------
	localparam logic DRIVE = 1'b0;
	localparam logic FLOAT = 1'b1;
	localparam logic [AD_W-1:0] AD_ONES = 32'hFFFF_FFFF;
	localparam logic [BE_W-1:0] BE_ONES = 4'hF;
	localparam logic [3:0] CMD_IO_RD = 4'h2;
	localparam logic [3:0] CMD_IO_WR = 4'h3;
	localparam logic [3:0] CMD_MEM_RD = 4'h6;
	localparam logic [3:0] CMD_MEM_WR = 4'h7;
	localparam int CMD_WR_BIT = 0;
	localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;

	// ----------------------------------------
	// State types
	// ----------------------------------------
	typedef enum logic [1:0] {
		M_IDLE = 2'b00,
		M_ADDR = 2'b01,
		M_DATA = 2'b10,
		M_TURN = 2'b11
	} init_state_t;

	typedef enum logic [1:0] {
		T_IDLE = 2'b00,
		T_DEC = 2'b01,
		T_DATA = 2'b10,
		T_TURN = 2'b11
	} targ_state_t;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Even parity over address/data and command/enables
	function automatic logic even_par(input logic [AD_W-1:0] ad,
		input logic [BE_W-1:0] cbe_n);
		return ^{ad, cbe_n}; // [R10]
	endfunction

	// Active-low enables to a lane mask, bit 3 for the top lane
	function automatic logic [AD_W-1:0] lane_mask(
		input logic [BE_W-1:0] cbe_n);
		logic [AD_W-1:0] m;
		m = '0;
		for (int i = 0; i < BE_W; i++) begin
			m[i*BYTE_W +: BYTE_W] = {BYTE_W{~cbe_n[i]}}; // [R9]
		end
		return m;
	endfunction

endpackage

// *** logic/pci_bus_if.sv ***
// Shared PCI address, data, command and handshake lines of two agents
`timescale 1ns/1ps
`default_nettype none
interface pci_bus_if;
	// ----------------------------------------
	// Initiator drivers, enables low to drive
	// ----------------------------------------
	logic [pci_pkg::AD_W-1:0] m_ad;
	logic m_ad_oe_n;
	logic [pci_pkg::BE_W-1:0] m_cbe_n;
	logic m_cbe_oe_n;
	logic m_par;
	logic m_par_oe_n;
	logic m_frame_n;
	logic m_irdy_n;
	logic m_ctl_oe_n;
	logic m_perr_n;
	logic m_perr_oe_n;

	// ----------------------------------------
	// Target drivers
	// ----------------------------------------
	logic [pci_pkg::AD_W-1:0] t_ad;
	logic t_ad_oe_n;
	logic t_par;
	logic t_par_oe_n;
	logic t_trdy_n;
	logic t_devsel_n;
	logic t_ctl_oe_n;

	// ----------------------------------------
	// Resolved lines, pulled up when nobody drives
	// ----------------------------------------
	wire [pci_pkg::AD_W-1:0] ad = !m_ad_oe_n ? m_ad :
		(!t_ad_oe_n ? t_ad : pci_pkg::AD_ONES);
	wire [pci_pkg::BE_W-1:0] cbe_n = !m_cbe_oe_n ? m_cbe_n :
		pci_pkg::BE_ONES;
	wire par = !m_par_oe_n ? m_par : (!t_par_oe_n ? t_par : 1'b1);
	wire frame_n = m_ctl_oe_n | m_frame_n;
	wire irdy_n = m_ctl_oe_n | m_irdy_n;
	wire trdy_n = t_ctl_oe_n | t_trdy_n;
	wire devsel_n = t_ctl_oe_n | t_devsel_n;
	wire perr_n = m_perr_oe_n | m_perr_n;

	modport initiator (
		output m_ad, m_ad_oe_n, m_cbe_n, m_cbe_oe_n, m_par, m_par_oe_n,
		output m_frame_n, m_irdy_n, m_ctl_oe_n, m_perr_n, m_perr_oe_n,
		input ad, cbe_n, par, frame_n, irdy_n, trdy_n, devsel_n, perr_n
	);

	modport target (
		output t_ad, t_ad_oe_n, t_par, t_par_oe_n,
		output t_trdy_n, t_devsel_n, t_ctl_oe_n,
		input ad, cbe_n, par, frame_n, irdy_n, trdy_n, devsel_n, perr_n
	);
endinterface
`default_nettype wire

// *** logic/pci_initiator.sv ***
// Write-data FIFO and the bus-master end of the PCI port
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// FIFO
// ----------------------------------------
module data_fifo #(
	parameter int WIDTH = pci_pkg::AD_W,
	parameter int DEPTH = pci_pkg::FIFO_DEPTH
) (
	// Clock and reset
	input wire logic clock_i,
	input wire logic sys_rst_i,
	// Fill side
	input wire logic in_valid_i,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic in_ready_o,
	// Drain side
	output logic out_valid_o,
	output logic [WIDTH-1:0] out_data_o,
	input wire logic out_ready_i
);
	localparam int PTR_W = $clog2(DEPTH);
	localparam logic [PTR_W:0] FULL = (PTR_W+1)'(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PTR_W-1:0] wr_ptr;
	logic [PTR_W-1:0] rd_ptr;
	logic [PTR_W:0] count;

	wire push = in_valid_i & in_ready_o;
	wire pop = out_valid_o & out_ready_i;
	wire [PTR_W:0] next_count = count + (PTR_W+1)'(push) -
		(PTR_W+1)'(pop);
	wire [PTR_W-1:0] next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;

	assign out_data_o = mem[rd_ptr];

	// Flags registered from the next count so both are honest at once
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
			in_ready_o <= 1'b0;
			out_valid_o <= 1'b0;
		end else begin
			wr_ptr <= push ? wr_ptr + 1'b1 : wr_ptr;
			rd_ptr <= next_rd_ptr;
			count <= next_count;
			in_ready_o <= next_count != FULL;
			out_valid_o <= next_count != '0;
		end
	end

	always_ff @(posedge clock_i) begin
		if (push) begin
			mem[wr_ptr] <= in_data_i;
		end
	end
endmodule

// ----------------------------------------
// Bus master
// ----------------------------------------
module pci_initiator (
	// Clock and reset
	input wire logic clock_i,
	input wire logic sys_rst_i,
	// Bus
	pci_bus_if.initiator bus,
	// Transfer request
	input wire logic start_i,
	input wire logic [3:0] cmd_i,
	input wire logic [pci_pkg::AD_W-1:0] addr_i,
	input wire logic [pci_pkg::CNT_W-1:0] len_i,
	input wire logic [pci_pkg::BE_W-1:0] be_i,
	output logic busy_o,
	output logic done_o,
	output logic abort_o,
	// Write data
	input wire logic wr_valid_i,
	input wire logic [pci_pkg::AD_W-1:0] wr_data_i,
	output logic wr_ready_o,
	// Read data
	output logic rd_valid_o,
	output logic [pci_pkg::AD_W-1:0] rd_data_o,
	output logic [pci_pkg::BE_W-1:0] rd_be_o,
	output logic perr_seen_o
);
	pci_pkg::init_state_t state, next_state;
	logic [3:0] cmd;
	logic [pci_pkg::BE_W-1:0] be;
	logic [pci_pkg::CNT_W-1:0] cnt;
	logic [2:0] wait_cnt;
	logic free_prev;
	logic chk;
	logic [pci_pkg::AD_W-1:0] cap_ad;
	logic [pci_pkg::BE_W-1:0] cap_cbe_n;
	logic fifo_valid;
	logic [pci_pkg::AD_W-1:0] fifo_data;

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	wire bus_free = bus.frame_n & bus.irdy_n;
	// Free for two sampled clocks, so the last owner let go a clock ago
	wire can_start = state == pci_pkg::M_IDLE & start_i & bus_free &
		free_prev; // [R2]
	wire is_wr = cmd[pci_pkg::CMD_WR_BIT];
	wire in_data = state == pci_pkg::M_DATA;
	wire done = in_data & !bus.irdy_n & !bus.trdy_n; // [R15]
	wire last = cnt == pci_pkg::CNT_ONE;
	wire abort = in_data & bus.devsel_n &
		wait_cnt == 3'(pci_pkg::DEVSEL_WAIT);
	wire finish = (done & last) | abort;
	wire need = is_wr & (state == pci_pkg::M_ADDR |
		(in_data & (bus.m_irdy_n | (done & !last))));
	wire ld = need & fifo_valid; // [R13]
	wire [pci_pkg::CNT_W-1:0] next_cnt = can_start ? len_i :
		(done ? cnt - 1'b1 : cnt);
	wire next_irdy_n = (state == pci_pkg::M_ADDR) ? (is_wr & !ld) :
		!in_data ? 1'b1 :
		finish ? 1'b1 :
		!is_wr ? 1'b0 :
		ld ? 1'b0 : (done | bus.m_irdy_n);
	// Frame drops together with ready on the final phase
	wire next_frame_n = can_start ? 1'b0 :
		(state == pci_pkg::M_ADDR | in_data) ?
		(finish | (!next_irdy_n & next_cnt == pci_pkg::CNT_ONE)) :
		1'b1; // [R16]
	wire next_wr = can_start ? cmd_i[pci_pkg::CMD_WR_BIT] : is_wr;
	wire drive_ad = next_state == pci_pkg::M_ADDR |
		(next_state == pci_pkg::M_DATA & next_wr); // [R3]
	wire err = chk & (bus.par != pci_pkg::even_par(cap_ad, cap_cbe_n));

	always_comb begin
		next_state = state;
		unique case (state)
			pci_pkg::M_IDLE: begin
				if (can_start) begin
					next_state = pci_pkg::M_ADDR; // [R4]
				end
			end
			pci_pkg::M_ADDR: begin
				next_state = pci_pkg::M_DATA;
			end
			pci_pkg::M_DATA: begin
				if (finish) begin
					next_state = pci_pkg::M_TURN;
				end
			end
			pci_pkg::M_TURN: begin
				next_state = pci_pkg::M_IDLE;
			end
		endcase
	end

	data_fifo #(
		.WIDTH(pci_pkg::AD_W),
		.DEPTH(pci_pkg::FIFO_DEPTH)
	) data_fifo_inst (
		.clock_i(clock_i),
		.sys_rst_i(sys_rst_i),
		.in_valid_i(wr_valid_i),
		.in_data_i(wr_data_i),
		.in_ready_o(wr_ready_o),
		.out_valid_o(fifo_valid),
		.out_data_o(fifo_data),
		.out_ready_i(ld)
	);

	// ----------------------------------------
	// Sequencing
	// ----------------------------------------
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			state <= pci_pkg::M_IDLE;
			cmd <= '0;
			be <= '0;
			cnt <= '0;
			wait_cnt <= '0;
			free_prev <= 1'b0;
			busy_o <= 1'b0;
			done_o <= 1'b0;
			abort_o <= 1'b0;
		end else begin
			state <= next_state;
			cmd <= can_start ? cmd_i : cmd;
			be <= can_start ? be_i : be;
			cnt <= next_cnt;
			wait_cnt <= (in_data & bus.devsel_n) ? wait_cnt + 1'b1 : '0;
			free_prev <= bus_free;
			busy_o <= next_state != pci_pkg::M_IDLE;
			done_o <= done & last;
			abort_o <= abort;
		end
	end

	// ----------------------------------------
	// Bus drivers
	// ----------------------------------------
	// Control lines stay driven through TURN, high, before release
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			bus.m_ad <= '0;
			bus.m_ad_oe_n <= pci_pkg::FLOAT;
			bus.m_cbe_n <= pci_pkg::BE_ONES;
			bus.m_cbe_oe_n <= pci_pkg::FLOAT;
			bus.m_frame_n <= 1'b1;
			bus.m_irdy_n <= 1'b1;
			bus.m_ctl_oe_n <= pci_pkg::FLOAT;
		end else begin
			bus.m_ad <= can_start ? addr_i : (ld ? fifo_data : bus.m_ad); // [R6]
			bus.m_ad_oe_n <= !drive_ad;
			bus.m_cbe_n <= can_start ? cmd_i :
				(state == pci_pkg::M_ADDR ? ~be : bus.m_cbe_n); // [R7]
			bus.m_cbe_oe_n <= next_state == pci_pkg::M_IDLE;
			bus.m_frame_n <= next_frame_n;
			bus.m_irdy_n <= next_irdy_n;
			bus.m_ctl_oe_n <= next_state == pci_pkg::M_IDLE; // [R1]
		end
	end

	// Parity follows what this end drove one clock earlier
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			bus.m_par <= 1'b0;
			bus.m_par_oe_n <= pci_pkg::FLOAT;
		end else begin
			bus.m_par <= pci_pkg::even_par(bus.m_ad, bus.m_cbe_n); // [R18]
			bus.m_par_oe_n <= bus.m_ad_oe_n; // [R14]
		end
	end

	// ----------------------------------------
	// Read capture and parity check
	// ----------------------------------------
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			chk <= 1'b0;
			cap_ad <= '0;
			cap_cbe_n <= '0;
			rd_valid_o <= 1'b0;
			rd_data_o <= '0;
			rd_be_o <= '0;
			perr_seen_o <= 1'b0;
			bus.m_perr_n <= 1'b1;
			bus.m_perr_oe_n <= pci_pkg::FLOAT;
		end else begin
			chk <= done & !is_wr; // [R12]
			cap_ad <= bus.ad;
			cap_cbe_n <= bus.cbe_n;
			rd_valid_o <= done & !is_wr;
			rd_data_o <= bus.ad & pci_pkg::lane_mask(bus.cbe_n); // [R8]
			rd_be_o <= ~bus.cbe_n;
			perr_seen_o <= err;
			bus.m_perr_n <= !err; // [R17]
			// Low first, then one driven-high clock, then float
			bus.m_perr_oe_n <= !(err | !bus.m_perr_n); // [R1]
		end
	end
endmodule
`default_nettype wire

// *** logic/pci_target.sv ***
// Memory-backed target end of the PCI port, standing for the host side
`timescale 1ns/1ps
`default_nettype none
module pci_target #(
	parameter int IDX_W = 4,
	parameter logic [pci_pkg::AD_W-1:0] BASE = 32'h0000_0000
) (
	// Clock and reset
	input wire logic clock_i,
	input wire logic sys_rst_i,
	// Bus
	pci_bus_if.target bus,
	// Write observation
	output logic wr_strobe_o,
	output logic [IDX_W-1:0] wr_index_o,
	output logic [pci_pkg::AD_W-1:0] wr_data_o,
	output logic [pci_pkg::BE_W-1:0] wr_be_o
);
	localparam int HI = IDX_W + pci_pkg::IDX_LSB;

	pci_pkg::targ_state_t state, next_state;
	logic [pci_pkg::AD_W-1:0] mem [2**IDX_W];
	logic [IDX_W-1:0] idx;
	logic is_wr;
	logic frame_prev;

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	wire [3:0] cmd = bus.cbe_n;
	wire cmd_ok = cmd == pci_pkg::CMD_MEM_RD | cmd == pci_pkg::CMD_MEM_WR |
		cmd == pci_pkg::CMD_IO_RD | cmd == pci_pkg::CMD_IO_WR;
	wire hit = bus.ad[pci_pkg::AD_W-1:HI] == BASE[pci_pkg::AD_W-1:HI];
	wire addr_phase = state == pci_pkg::T_IDLE & frame_prev &
		!bus.frame_n; // [R4]
	wire claim = addr_phase & cmd_ok & hit;
	// Both address kinds pick a word; the low address bits are unused, lanes come from the enables
	wire [IDX_W-1:0] addr_idx = bus.ad[HI-1:pci_pkg::IDX_LSB]; // [R5]
	wire in_data = state == pci_pkg::T_DATA;
	wire done = in_data & !bus.irdy_n & !bus.trdy_n; // [R15]
	wire gone = in_data & bus.frame_n & bus.irdy_n;
	wire [IDX_W-1:0] next_idx = claim ? addr_idx : (done ? idx + 1'b1 : idx);
	wire [pci_pkg::AD_W-1:0] mask = pci_pkg::lane_mask(bus.cbe_n);
	// Claiming edge must use the new command, not the last transfer's
	wire next_wr = claim ? cmd[pci_pkg::CMD_WR_BIT] : is_wr;
	wire drive_ad = next_state == pci_pkg::T_DATA & !next_wr; // [R14]

	always_comb begin
		next_state = state;
		unique case (state)
			pci_pkg::T_IDLE: begin
				if (claim) begin
					next_state = cmd[pci_pkg::CMD_WR_BIT] ? pci_pkg::T_DATA :
						pci_pkg::T_DEC; // [R2]
				end
			end
			pci_pkg::T_DEC: begin
				next_state = pci_pkg::T_DATA;
			end
			pci_pkg::T_DATA: begin
				if ((done & bus.frame_n) | gone) begin
					next_state = pci_pkg::T_TURN; // [R16]
				end
			end
			pci_pkg::T_TURN: begin
				next_state = pci_pkg::T_IDLE;
			end
		endcase
	end

	// ----------------------------------------
	// Sequencing and storage
	// ----------------------------------------
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			state <= pci_pkg::T_IDLE;
			idx <= '0;
			is_wr <= 1'b0;
			frame_prev <= 1'b1;
			wr_strobe_o <= 1'b0;
			wr_index_o <= '0;
			wr_data_o <= '0;
			wr_be_o <= '0;
		end else begin
			state <= next_state;
			idx <= next_idx;
			is_wr <= next_wr;
			frame_prev <= bus.frame_n;
			wr_strobe_o <= done & is_wr;
			wr_index_o <= idx;
			wr_data_o <= bus.ad & mask; // [R8]
			wr_be_o <= ~bus.cbe_n;
		end
	end

	// Only enabled lanes change; the rest of the word keeps its value
	always_ff @(posedge clock_i) begin
		if (done & is_wr) begin
			mem[idx] <= (mem[idx] & ~mask) | (bus.ad & mask); // [R9]
		end
	end

	// ----------------------------------------
	// Bus drivers
	// ----------------------------------------
	// Address lines are taken only after the turnaround clock
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			bus.t_ad <= '0;
			bus.t_ad_oe_n <= pci_pkg::FLOAT;
			bus.t_trdy_n <= 1'b1;
			bus.t_devsel_n <= 1'b1;
			bus.t_ctl_oe_n <= pci_pkg::FLOAT;
		end else begin
			bus.t_ad <= mem[next_idx]; // [R6]
			bus.t_ad_oe_n <= !drive_ad; // [R3]
			bus.t_trdy_n <= next_state != pci_pkg::T_DATA;
			bus.t_devsel_n <= !(next_state == pci_pkg::T_DEC |
				next_state == pci_pkg::T_DATA);
			bus.t_ctl_oe_n <= next_state == pci_pkg::T_IDLE; // [R1]
		end
	end

	// Read parity: one clock after this end drove the data
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			bus.t_par <= 1'b0;
			bus.t_par_oe_n <= pci_pkg::FLOAT;
		end else begin
			bus.t_par <= pci_pkg::even_par(bus.t_ad, bus.cbe_n); // [R18]
			bus.t_par_oe_n <= bus.t_ad_oe_n; // [R14]
		end
	end
endmodule
`default_nettype wire

// *** testbench/pci_bus_props.sv ***
// Concurrent checks on the shared lines between the two PCI ends
`timescale 1ns/1ps
`default_nettype none
module pci_bus_props (
	// Clock and reset
	input wire logic clock_i,
	input wire logic sys_rst_i,
	// Initiator drivers
	input wire logic m_ad_oe_n,
	input wire logic m_cbe_oe_n,
	input wire logic m_par,
	input wire logic m_par_oe_n,
	input wire logic m_frame_n,
	input wire logic m_irdy_n,
	input wire logic m_ctl_oe_n,
	// Target drivers
	input wire logic t_ad_oe_n,
	input wire logic t_par,
	input wire logic t_par_oe_n,
	input wire logic t_trdy_n,
	input wire logic t_devsel_n,
	input wire logic t_ctl_oe_n,
	// Resolved lines
	input wire logic [31:0] ad,
	input wire logic [3:0] cbe_n,
	input wire logic frame_n,
	input wire logic irdy_n,
	input wire logic trdy_n,
	input wire logic devsel_n
);
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (sys_rst_i);

	// ----------------------------------------
	// Phases
	// ----------------------------------------
	sequence addr_phase;
		$fell(frame_n);
	endsequence
	sequence data_phase;
		!irdy_n && !trdy_n;
	endsequence

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	a_addr_cmd_drive: assert property (addr_phase |->
		!m_ad_oe_n && !m_cbe_oe_n && cbe_n inside {4'h2, 4'h3, 4'h6, 4'h7})
		else $error("address phase not driven with a command");
	a_addr_par_next: assert property (addr_phase |=>
		!m_par_oe_n && t_par_oe_n)
		else $error("address parity missing the next clock");
	a_init_par_even: assert property (!m_par_oe_n |->
		!$past(m_ad_oe_n) && m_par == ^{$past(ad), $past(cbe_n)})
		else $error("initiator parity wrong");
	a_targ_par_even: assert property (!t_par_oe_n |->
		!$past(t_ad_oe_n) && t_par == ^{$past(ad), $past(cbe_n)})
		else $error("target parity wrong");
	a_write_par_due: assert property (!m_ad_oe_n && !irdy_n |=>
		!m_par_oe_n)
		else $error("write parity late");
	a_read_par_due: assert property (!t_ad_oe_n && !trdy_n |=>
		!t_par_oe_n)
		else $error("read parity late");
	a_single_par_driver: assert property (m_par_oe_n || t_par_oe_n)
		else $error("both ends drive parity");
	a_init_ctl_release: assert property ($rose(m_ctl_oe_n) |->
		$past(m_frame_n) && $past(m_irdy_n))
		else $error("initiator released control lines while low");
	a_targ_ctl_release: assert property ($rose(t_ctl_oe_n) |->
		$past(t_trdy_n) && $past(t_devsel_n))
		else $error("target released control lines while low");
	a_ad_turn_gap: assert property ($fell(t_ad_oe_n) |->
		m_ad_oe_n && $past(m_ad_oe_n))
		else $error("target drove data without a turnaround clock");
	a_frame_last_phase: assert property ($rose(frame_n) && !devsel_n |->
		!irdy_n)
		else $error("frame ended outside the final data phase");
	a_data_follows: assert property (addr_phase ##1 !devsel_n |->
		##[0:8] data_phase)
		else $error("no data phase after a claimed address");
endmodule
`default_nettype wire

// *** testbench/tb_pci_address_data_parity.sv ***
// Self-checking bench for both PCI ends and a faulty far side
`timescale 1ns/1ps
`default_nettype none
module tb_pci_address_data_parity;
	logic clock_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic start_i = 1'b0;
	logic start2 = 1'b0;
	logic [3:0] cmd_i = 4'h0;
	logic [31:0] addr_i = 32'h0;
	logic [7:0] len_i = 8'h01;
	logic [3:0] be_i = 4'hF;
	logic wr_valid_i = 1'b0;
	logic [31:0] wr_data_i = 32'h0;
	logic busy_o, done_o, abort_o, wr_ready_o, rd_valid_o, perr_seen_o;
	logic [31:0] rd_data_o, wr_data_o;
	logic [3:0] rd_be_o, wr_be_o, wr_index_o;
	logic wr_strobe_o;
	logic perr2;
	logic [47:0] wq[$];
	logic [47:0] rq[$];
	int fails = 0;
	int n_tests = 0;
	int seen_abort;
	int seen_perr;

	// ----------------------------------------
	// Design
	// ----------------------------------------
	pci_bus_if bus();
	pci_bus_if bus2();
	pci_initiator pci_initiator_inst (.clock_i, .sys_rst_i, .bus(bus),
		.start_i, .cmd_i, .addr_i, .len_i, .be_i, .busy_o, .done_o, .abort_o,
		.wr_valid_i, .wr_data_i, .wr_ready_o, .rd_valid_o, .rd_data_o,
		.rd_be_o, .perr_seen_o);
	// Second end faces a bench-driven target that breaks parity
	pci_initiator pci_initiator_inst2 (.clock_i, .sys_rst_i, .bus(bus2),
		.start_i(start2), .cmd_i, .addr_i, .len_i, .be_i, .busy_o(),
		.done_o(), .abort_o(), .wr_valid_i, .wr_data_i, .wr_ready_o(),
		.rd_valid_o(), .rd_data_o(), .rd_be_o(), .perr_seen_o(perr2));
	pci_target pci_target_inst (.clock_i, .sys_rst_i, .bus(bus),
		.wr_strobe_o, .wr_index_o, .wr_data_o, .wr_be_o);
	pci_bus_props pci_bus_props_inst (.clock_i, .sys_rst_i,
		.m_ad_oe_n(bus.m_ad_oe_n), .m_cbe_oe_n(bus.m_cbe_oe_n),
		.m_par(bus.m_par), .m_par_oe_n(bus.m_par_oe_n),
		.m_frame_n(bus.m_frame_n), .m_irdy_n(bus.m_irdy_n),
		.m_ctl_oe_n(bus.m_ctl_oe_n), .t_ad_oe_n(bus.t_ad_oe_n),
		.t_par(bus.t_par), .t_par_oe_n(bus.t_par_oe_n),
		.t_trdy_n(bus.t_trdy_n), .t_devsel_n(bus.t_devsel_n),
		.t_ctl_oe_n(bus.t_ctl_oe_n), .ad(bus.ad), .cbe_n(bus.cbe_n),
		.frame_n(bus.frame_n), .irdy_n(bus.irdy_n), .trdy_n(bus.trdy_n),
		.devsel_n(bus.devsel_n));

	always #2.5 clock_i = ~clock_i;

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic check(input string what, input logic [47:0] seen, exp);
		n_tests++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wrap_up();
		$display("Comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// Word k of a fill is base times k+1, so every word differs
	task automatic fill(input int n, input logic [31:0] base, output int got);
		got = 0;
		while (got < n && wr_ready_o === 1'b1) begin
			wr_valid_i = 1'b1;
			wr_data_i = 32'(base * (got + 1));
			@(negedge clock_i);
			got++;
		end
		wr_valid_i = 1'b0;
	endtask

	// Start is a level, so it is held until busy shows it was taken
	task automatic run(input logic [3:0] c, input logic [31:0] a,
		input logic [7:0] n, input logic [3:0] b);
		int k;
		int tail;
		wq.delete();
		rq.delete();
		seen_abort = 0;
		seen_perr = 0;
		tail = -1;
		cmd_i = c;
		addr_i = a;
		len_i = n;
		be_i = b;
		start_i = 1'b1;
		for (k = 0; k < 200 && tail != 0; k++) begin
			@(negedge clock_i);
			if (busy_o === 1'b1)
				start_i = 1'b0;
			if (wr_strobe_o === 1'b1)
				wq.push_back({8'h0, wr_index_o, wr_be_o, wr_data_o});
			if (rd_valid_o === 1'b1)
				rq.push_back({12'h0, rd_be_o, rd_data_o});
			if (abort_o === 1'b1)
				seen_abort = 1;
			if (perr_seen_o === 1'b1)
				seen_perr = 1;
			if (tail > 0)
				tail--;
			else if (tail < 0 && (done_o === 1'b1 || abort_o === 1'b1))
				tail = 4;
		end
		if (tail != 0) begin
			check("transfer end", 48'(tail), 48'h0);
			wrap_up();
		end
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_write_one();
		int got;
		fill(1, 32'hA1B2_C3D4, got);
		run(pci_pkg::CMD_MEM_WR, 32'h0000_0008, 8'h01, 4'h9);
		check("write count", wq.size(), 1);
		check("write lanes", wq[0], {8'h0, 4'h2, 4'h9,
			32'hA100_00D4});
		$display("write_one finished");
	endtask

	task automatic t_burst();
		int got;
		int k;
		fill(9, 32'h1111_1111, got);
		check("fill accepted", got, 8);
		check("full refuses", wr_ready_o, 1'b0);
		run(pci_pkg::CMD_MEM_WR, 32'h0000_0000, 8'h08, 4'hF);
		check("burst count", wq.size(), 8);
		for (k = 0; k < 8; k++)
			check("burst word", wq[k], {8'h0, 4'(k), 4'hF,
				32'(32'h1111_1111 * (k + 1))});
		check("drained ready", wr_ready_o, 1'b1);
		$display("burst finished");
	endtask

	task automatic t_read_back();
		int k;
		run(pci_pkg::CMD_MEM_RD, 32'h0000_0004, 8'h02, 4'h6);
		check("read count", rq.size(), 2);
		check("read parity clean", seen_perr, 0);
		for (k = 0; k < 2; k++)
			check("read word", rq[k], {12'h0, 4'h6,
				32'(32'h1111_1111 * (k + 2)) & 32'h00FF_FF00});
		$display("read_back finished");
	endtask

	// Byte address 0x0C lands on word 3; only lane 1 may change
	task automatic t_io();
		int got;
		fill(1, 32'hDEAD_BEEF, got);
		run(pci_pkg::CMD_IO_WR, 32'h0000_000C, 8'h01, 4'h2);
		check("io write", wq[0], {8'h0, 4'h3, 4'h2, 32'h0000_BE00});
		run(pci_pkg::CMD_IO_RD, 32'h0000_000C, 8'h01, 4'hF);
		check("io read", rq[0], {12'h0, 4'hF, 32'h4444_BE44});
		$display("io finished");
	endtask

	task automatic t_unclaimed();
		run(pci_pkg::CMD_MEM_RD, 32'h0000_1000, 8'h01, 4'hF);
		check("abort seen", seen_abort, 1);
		check("no read data", rq.size(), 0);
		$display("unclaimed finished");
	endtask

	// Data 5A5A0F0E has odd ones, so even parity is 1 and 0 is wrong
	task automatic t_perr();
		int k;
		cmd_i = pci_pkg::CMD_MEM_RD;
		len_i = 8'h01;
		be_i = 4'hF;
		start2 = 1'b1;
		for (k = 0; k < 20 && bus2.frame_n !== 1'b0; k++)
			@(negedge clock_i);
		start2 = 1'b0;
		check("fault frame", bus2.frame_n, 1'b0);
		@(negedge clock_i);
		bus2.t_devsel_n = 1'b0;
		bus2.t_ctl_oe_n = 1'b0;
		@(negedge clock_i);
		bus2.t_ad = 32'h5A5A_0F0E;
		bus2.t_ad_oe_n = 1'b0;
		bus2.t_trdy_n = 1'b0;
		@(negedge clock_i);
		bus2.t_ad_oe_n = 1'b1;
		bus2.t_par = 1'b0;
		bus2.t_par_oe_n = 1'b0;
		bus2.t_trdy_n = 1'b1;
		bus2.t_devsel_n = 1'b1;
		@(negedge clock_i);
		check("parity error line", bus2.perr_n, 1'b0);
		check("parity error flag", perr2, 1'b1);
		bus2.t_par_oe_n = 1'b1;
		bus2.t_ctl_oe_n = 1'b1;
		repeat (4) @(negedge clock_i);
		$display("parity_error finished");
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		bus2.t_ad = 32'h0;
		bus2.t_ad_oe_n = 1'b1;
		bus2.t_par = 1'b0;
		bus2.t_par_oe_n = 1'b1;
		bus2.t_trdy_n = 1'b1;
		bus2.t_devsel_n = 1'b1;
		bus2.t_ctl_oe_n = 1'b1;
		repeat (20) @(negedge clock_i);
		sys_rst_i = 1'b0;
		repeat (2) @(negedge clock_i);
		t_write_one();
		t_burst();
		t_read_back();
		t_io();
		t_unclaimed();
		t_perr();
		wrap_up();
	end
endmodule
`default_nettype wire
